// File: rtl/tuning_word_history_holdover.sv
`timescale 1ns/1ps

module tuning_word_history_holdover #(
  parameter int unsigned MS_CYCLES = tw_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Loop filter and reference monitors
  input wire logic [47:0] loop_word_i,
  input wire logic loop_word_valid_i,
  input wire logic [3:0] ref_valid_i,
  // Multifunction pins
  input wire logic mf_hist_clear_i,
  output logic mf_strobe_o,
  // Synthesizer and loop control
  output logic [47:0] tuning_word_o,
  output logic closed_loop_o,
  output logic profile_load_o,
  output logic [1:0] profile_ref_o,
  output logic lock_freeze_o
);

  function automatic logic idx_hit(input logic [15:0] addr, input logic [13:0] idx);
    idx_hit = (addr[15:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Registers.
  logic [47:0] free_running_tuning_word;
  logic [23:0] averaging_interval_timer;
  logic [7:0] averaging_options;
  logic [7:0] loop_state_control;
  logic [7:0] event_mask;
  logic [47:0] stored_average_word;
  logic hist_valid;
  logic hist_updated;

  // Loop state.
  tw_pkg::loop_state_e state;
  tw_pkg::loop_state_e next_state;
  logic [1:0] active_ref;
  logic [47:0] hold_word;

  // Accumulation.
  logic [tw_pkg::SUM_W-1:0] acc_sum;
  logic [tw_pkg::CNT_W-1:0] acc_cnt;
  logic [23:0] ms_count;
  logic [19:0] ms_div;
  logic first_interval;
  logic [2:0] mid_shift;

  // Divider.
  logic div_busy;
  logic [6:0] div_steps;
  logic [tw_pkg::SUM_W-1:0] div_quo;
  logic [tw_pkg::CNT_W:0] div_rem;
  logic [tw_pkg::CNT_W-1:0] div_den;

  // Pin synchroniser and bus.
  logic clr_pin_meta;
  logic clr_pin_sync;
  logic bus_wr;
  logic bus_rd;

  assign bus_wr = psel_i & penable_i & pready_o & pwrite_i;
  assign bus_rd = psel_i & penable_i & ~pready_o & ~pwrite_i;

  // Reference selection.
  logic [1:0] sel_ref;
  logic sel_ok;
  logic force_free;
  logic user_hold;
  logic new_ref;
  always_comb begin
    sel_ref = 2'b00;
    if (loop_state_control[tw_pkg::LOOP_FORCE_REF_BIT]) begin
      sel_ref = loop_state_control[tw_pkg::LOOP_REF_LSB +: 2];
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (ref_valid_i[i]) begin
          sel_ref = 2'(i);
        end
      end
    end
  end
  assign sel_ok = ref_valid_i[sel_ref];
  assign force_free = loop_state_control[tw_pkg::LOOP_FREE_RUN_BIT];
  assign user_hold = loop_state_control[tw_pkg::LOOP_USER_HOLD_BIT];

  always_comb begin
    next_state = state;
    unique case (state)
      tw_pkg::ST_FREE_RUN: begin
        if (!force_free) begin
          next_state = sel_ok && !user_hold ? tw_pkg::ST_CLOSED : tw_pkg::ST_HOLDOVER;
        end
      end
      tw_pkg::ST_CLOSED: begin
        if (force_free) begin
          next_state = tw_pkg::ST_FREE_RUN;
        end else if (user_hold || !sel_ok) begin
          next_state = tw_pkg::ST_HOLDOVER;
        end else if (sel_ref != active_ref) begin
          next_state = tw_pkg::ST_SWITCH;
        end
      end
      tw_pkg::ST_SWITCH: begin
        next_state = force_free ? tw_pkg::ST_FREE_RUN : tw_pkg::ST_CLOSED;
      end
      tw_pkg::ST_HOLDOVER: begin
        if (force_free) begin
          next_state = tw_pkg::ST_FREE_RUN;
        end else if (!user_hold && sel_ok) begin
          next_state = tw_pkg::ST_CLOSED;
        end
      end
      default: next_state = tw_pkg::ST_FREE_RUN;
    endcase
  end

  // A lock or a switchover onto a reference other than the last one restarts the history.
  // It is taken on entry to switchover, because active_ref already follows the new one after it.
  assign new_ref = ((next_state == tw_pkg::ST_CLOSED) || (next_state == tw_pkg::ST_SWITCH)) &&
                   (sel_ref != active_ref);

  // Loop state, profile and holdover word.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= tw_pkg::ST_FREE_RUN;
      active_ref <= 2'b00;
      hold_word <= 48'h0000_0000_0000;
      profile_load_o <= 1'b0;
      profile_ref_o <= 2'b00;
      lock_freeze_o <= 1'b0;
      closed_loop_o <= 1'b0;
    end else begin
      state <= next_state;
      profile_load_o <= next_state != state;
      closed_loop_o <= next_state == tw_pkg::ST_CLOSED;
      lock_freeze_o <= next_state == tw_pkg::ST_SWITCH;
      if (next_state == tw_pkg::ST_CLOSED || next_state == tw_pkg::ST_SWITCH) begin
        active_ref <= sel_ref;
        profile_ref_o <= sel_ref;
      end
      // Latched on every entry to holdover or switchover, so holdover straight from free-run has a word too.
      if (next_state != state && (next_state == tw_pkg::ST_HOLDOVER || next_state == tw_pkg::ST_SWITCH)) begin
        if (hist_valid) begin
          hold_word <= stored_average_word;
        end else if (averaging_options[tw_pkg::OPT_FALLBACK_BIT]) begin
          hold_word <= tuning_word_o;
        end else begin
          hold_word <= free_running_tuning_word;
        end
      end
    end
  end

  // Word fed to the synthesizer.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tuning_word_o <= tw_pkg::RST_FREE_WORD;
    end else begin
      unique case (state)
        tw_pkg::ST_FREE_RUN: tuning_word_o <= free_running_tuning_word;
        tw_pkg::ST_CLOSED: tuning_word_o <= loop_word_i;
        default: tuning_word_o <= hold_word;
      endcase
    end
  end

  // History clear sources.
  logic clear_hist;
  logic restart;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_pin_meta <= 1'b0;
      clr_pin_sync <= 1'b0;
    end else begin
      clr_pin_meta <= mf_hist_clear_i;
      clr_pin_sync <= clr_pin_meta;
    end
  end
  assign clear_hist = clr_pin_sync || (bus_wr && idx_hit(paddr_i, tw_pkg::IDX_HIST_CLEAR) &&
                      pwdata_i[tw_pkg::CLEAR_HIST_BIT]) ||
                      (new_ref && !averaging_options[tw_pkg::OPT_PERSIST_BIT]);
  assign restart = clear_hist || new_ref;

  // Interval timing and sample accumulation.
  logic ms_tick;
  logic full_end;
  logic mid_point;
  logic launch;
  assign ms_tick = (state == tw_pkg::ST_CLOSED) && (ms_div == 20'(MS_CYCLES - 1));
  assign full_end = ms_tick && ((ms_count + 24'h00_0001) >= averaging_interval_timer);
  assign mid_point = first_interval && (mid_shift != 3'b000) &&
                     (ms_count >= (averaging_interval_timer >> mid_shift));
  assign launch = full_end || (mid_point && !div_busy && acc_cnt != '0);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_sum <= '0;
      acc_cnt <= '0;
      ms_count <= 24'h00_0000;
      ms_div <= 20'h0_0000;
      first_interval <= 1'b1;
      mid_shift <= 3'b000;
      mf_strobe_o <= 1'b0;
    end else begin
      mf_strobe_o <= full_end;
      if (restart) begin
        acc_sum <= '0;
        acc_cnt <= '0;
        ms_count <= 24'h00_0000;
        ms_div <= 20'h0_0000;
        first_interval <= clear_hist;
        mid_shift <= clear_hist ? averaging_options[tw_pkg::OPT_K_LSB +: 3] : 3'b000;
      end else if (state == tw_pkg::ST_CLOSED) begin
        ms_div <= ms_tick ? 20'h0_0000 : ms_div + 20'h0_0001;
        if (full_end) begin
          // Each interval starts from the sample of its boundary cycle alone, so the mean never mixes intervals.
          acc_sum <= tw_pkg::SUM_W'(loop_word_valid_i ? loop_word_i : 48'h0000_0000_0000);
          acc_cnt <= tw_pkg::CNT_W'(loop_word_valid_i);
          ms_count <= 24'h00_0000;
          first_interval <= 1'b0;
          mid_shift <= 3'b000;
        end else begin
          if (loop_word_valid_i) begin
            acc_sum <= acc_sum + tw_pkg::SUM_W'(loop_word_i);
            acc_cnt <= acc_cnt + tw_pkg::CNT_W'(1);
          end
          if (ms_tick) begin
            ms_count <= ms_count + 24'h00_0001;
          end
          // A checkpoint with no samples yet, or a busy divider, is simply passed or retried.
          if (mid_point && (acc_cnt == '0 || !div_busy)) begin
            mid_shift <= mid_shift - 3'b001;
          end
        end
      end
    end
  end

  // Sequential restoring divider; the mean is ready 88 cycles after launch.
  logic [tw_pkg::CNT_W:0] rem_shift;
  logic [tw_pkg::CNT_W:0] rem_diff;
  assign rem_shift = {div_rem[tw_pkg::CNT_W-1:0], div_quo[tw_pkg::SUM_W-1]};
  assign rem_diff = rem_shift - {1'b0, div_den};

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_busy <= 1'b0;
      div_steps <= 7'h00;
      div_quo <= '0;
      div_rem <= '0;
      div_den <= '0;
      stored_average_word <= 48'h0000_0000_0000;
      hist_valid <= 1'b0;
    end else begin
      if (clear_hist) begin
        div_busy <= 1'b0;
        hist_valid <= 1'b0;
      end else if (launch && acc_cnt != '0) begin
        div_busy <= 1'b1;
        div_steps <= tw_pkg::DIV_STEPS;
        div_quo <= acc_sum;
        div_rem <= '0;
        div_den <= acc_cnt;
      end else if (div_busy) begin
        if (!rem_diff[tw_pkg::CNT_W]) begin
          div_rem <= rem_diff;
          div_quo <= {div_quo[tw_pkg::SUM_W-2:0], 1'b1};
        end else begin
          div_rem <= rem_shift;
          div_quo <= {div_quo[tw_pkg::SUM_W-2:0], 1'b0};
        end
        div_steps <= div_steps - 7'h01;
        if (div_steps == 7'h01) begin
          div_busy <= 1'b0;
          stored_average_word <= !rem_diff[tw_pkg::CNT_W] ? {div_quo[46:0], 1'b1} : {div_quo[46:0], 1'b0};
          hist_valid <= 1'b1;
        end
      end
    end
  end

  // Software registers.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      free_running_tuning_word <= tw_pkg::RST_FREE_WORD;
      averaging_interval_timer <= tw_pkg::RST_AVG_INTERVAL;
      averaging_options <= tw_pkg::RST_AVG_OPTIONS;
      loop_state_control <= tw_pkg::RST_LOOP_CTRL;
      event_mask <= tw_pkg::RST_EVENT_MASK;
    end else if (bus_wr) begin
      if (idx_hit(paddr_i, tw_pkg::IDX_FREE_WORD_LO)) begin
        free_running_tuning_word[31:0] <= pwdata_i;
      end
      if (idx_hit(paddr_i, tw_pkg::IDX_FREE_WORD_HI)) begin
        free_running_tuning_word[47:32] <= pwdata_i[15:0];
      end
      if (idx_hit(paddr_i, tw_pkg::IDX_AVG_INTERVAL)) begin
        averaging_interval_timer <= pwdata_i[23:0];
      end
      if (idx_hit(paddr_i, tw_pkg::IDX_AVG_OPTIONS)) begin
        averaging_options <= pwdata_i[7:0];
      end
      if (idx_hit(paddr_i, tw_pkg::IDX_LOOP_CTRL)) begin
        loop_state_control <= pwdata_i[7:0];
      end
      if (idx_hit(paddr_i, tw_pkg::IDX_EVENT_MASK)) begin
        event_mask <= pwdata_i[7:0];
      end
    end
  end

  // History-updated flag: a strobe in the same cycle as its clear keeps it set.
  logic upd_clear;
  assign upd_clear = bus_wr && idx_hit(paddr_i, tw_pkg::IDX_STATUS) && pwdata_i[tw_pkg::STAT_UPDATED_BIT];
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hist_updated <= 1'b0;
    end else if (full_end && event_mask[tw_pkg::MASK_UPDATED_BIT]) begin
      hist_updated <= 1'b1;
    end else if (upd_clear) begin
      hist_updated <= 1'b0;
    end
  end

  // APB answer: one wait state so that read data and ready come from flip-flops.
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (idx_hit(paddr_i, tw_pkg::IDX_FREE_WORD_LO)) begin
      rd_mux = free_running_tuning_word[31:0];
    end else if (idx_hit(paddr_i, tw_pkg::IDX_FREE_WORD_HI)) begin
      rd_mux = {16'h0000, free_running_tuning_word[47:32]};
    end else if (idx_hit(paddr_i, tw_pkg::IDX_AVG_INTERVAL)) begin
      rd_mux = {8'h00, averaging_interval_timer};
    end else if (idx_hit(paddr_i, tw_pkg::IDX_AVG_OPTIONS)) begin
      rd_mux = {24'h00_0000, averaging_options};
    end else if (idx_hit(paddr_i, tw_pkg::IDX_LOOP_CTRL)) begin
      rd_mux = {24'h00_0000, loop_state_control};
    end else if (idx_hit(paddr_i, tw_pkg::IDX_HIST_CLEAR)) begin
      rd_mux = 32'h0000_0000;
    end else if (idx_hit(paddr_i, tw_pkg::IDX_EVENT_MASK)) begin
      rd_mux = {24'h00_0000, event_mask};
    end else if (idx_hit(paddr_i, tw_pkg::IDX_STATUS)) begin
      rd_mux[tw_pkg::STAT_VALID_BIT] = hist_valid;
      rd_mux[tw_pkg::STAT_UPDATED_BIT] = hist_updated;
      rd_mux[tw_pkg::STAT_STATE_LSB +: 4] = state;
      rd_mux[tw_pkg::STAT_REF_LSB +: 2] = active_ref;
    end else if (idx_hit(paddr_i, tw_pkg::IDX_STORED_AVG_LO)) begin
      rd_mux = stored_average_word[31:0];
    end else if (idx_hit(paddr_i, tw_pkg::IDX_STORED_AVG_HI)) begin
      rd_mux = {16'h0000, stored_average_word[47:32]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~rd_hit;
      prdata_o <= bus_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// File: rtl/tw_pkg.sv
package tw_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [13:0] IDX_FREE_WORD_LO = 14'h0300;
  localparam logic [13:0] IDX_FREE_WORD_HI = 14'h0301;
  localparam logic [13:0] IDX_AVG_INTERVAL = 14'h0318;
  localparam logic [13:0] IDX_AVG_OPTIONS = 14'h031B;
  localparam logic [13:0] IDX_LOOP_CTRL = 14'h0A01;
  localparam logic [13:0] IDX_HIST_CLEAR = 14'h0A03;
  localparam logic [13:0] IDX_STATUS = 14'h0D10;
  localparam logic [13:0] IDX_EVENT_MASK = 14'h0D12;
  localparam logic [13:0] IDX_STORED_AVG_LO = 14'h0D14;
  localparam logic [13:0] IDX_STORED_AVG_HI = 14'h0D15;

  // Field positions.
  localparam int OPT_K_LSB = 0;
  localparam int OPT_PERSIST_BIT = 3;
  localparam int OPT_FALLBACK_BIT = 4;
  localparam int LOOP_REF_LSB = 0;
  localparam int LOOP_FORCE_REF_BIT = 4;
  localparam int LOOP_FREE_RUN_BIT = 5;
  localparam int LOOP_USER_HOLD_BIT = 6;
  localparam int CLEAR_HIST_BIT = 2;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_UPDATED_BIT = 1;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_REF_LSB = 8;
  localparam int MASK_UPDATED_BIT = 0;

  // Reset values.
  localparam logic [47:0] RST_FREE_WORD = 48'h0000_0000_0000;
  localparam logic [23:0] RST_AVG_INTERVAL = 24'h00_0001;
  localparam logic [7:0] RST_AVG_OPTIONS = 8'h00;
  localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;

  // Timing: one millisecond of the 40 ns system clock.
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // Averaging arithmetic widths and divider length.
  localparam int WORD_W = 48;
  localparam int CNT_W = 40;
  localparam int SUM_W = 88;
  localparam logic [6:0] DIV_STEPS = 7'h58;

  typedef enum logic [3:0] {
    ST_FREE_RUN = 4'b0001,
    ST_CLOSED = 4'b0010,
    ST_HOLDOVER = 4'b0100,
    ST_SWITCH = 4'b1000
  } loop_state_e;

endpackage

// File: tb/tuning_word_history_holdover_asserts.sv
`timescale 1ns/1ps
module tuning_word_history_holdover_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Loop side
  input wire logic mf_strobe_o,
  input wire logic closed_loop_o,
  input wire logic profile_load_o,
  input wire logic lock_freeze_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_ready_wait: assert property (psel_i && !penable_i ##1 psel_i && penable_i |=> pready_o)
    else $error("ready not given in the second access cycle");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready stayed high");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data driven outside a completion");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  chk_profile_change: assert property (!$stable(closed_loop_o) |-> profile_load_o)
    else $error("loop state changed without a profile load");
  chk_freeze_short: assert property (lock_freeze_o |=> !lock_freeze_o ##0 profile_load_o)
    else $error("switchover did not recover at once");
  chk_freeze_open: assert property (lock_freeze_o |-> !closed_loop_o)
    else $error("freeze while closed loop");
  chk_freeze_entry: assert property ($rose(lock_freeze_o) |-> $past(closed_loop_o))
    else $error("switchover not entered from closed loop");
  chk_strobe_pulse: assert property (mf_strobe_o |=> !mf_strobe_o)
    else $error("interval strobe longer than one cycle");
  cover property (mf_strobe_o);
  cover property (lock_freeze_o);
  cover property (pslverr_o);
  cover property ($fell(closed_loop_o));
endmodule

bind tuning_word_history_holdover tuning_word_history_holdover_asserts chk_u (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .mf_strobe_o(mf_strobe_o), .closed_loop_o(closed_loop_o),
  .profile_load_o(profile_load_o), .lock_freeze_o(lock_freeze_o)
);

// File: tb/loop_filter_model.sv
`timescale 1ns/1ps
module loop_filter_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bench control
  input wire logic hold_i,
  input wire logic slow_i,
  input wire logic [47:0] base_i,
  // Samples to the block
  output logic [47:0] word_o,
  output logic valid_o
);
  logic [1:0] cnt;
  // Off-sample cycles carry the inverted word, so a stale value is never averaged by luck.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 2'h0;
      valid_o <= 1'b0;
      word_o <= 48'h0000_0000_0000;
    end else begin
      cnt <= cnt + 2'h1;
      valid_o <= !hold_i && (!slow_i || cnt == 2'h3);
      word_o <= (!hold_i && (!slow_i || cnt == 2'h3)) ? base_i : ~base_i;
    end
  end
endmodule

// File: tb/tuning_word_history_holdover_bench.sv
`timescale 1ns/1ps
module tuning_word_history_holdover_bench;
  typedef struct packed {logic wr; logic [13:0] idx; logic [31:0] wd; logic [31:0] exp; logic err;} row_s;
  localparam logic [47:0] FREE_W = 48'h3333_1111_2222;
  localparam logic [47:0] WORD_A = 48'h0123_4567_89ab;
  localparam logic [47:0] WORD_B = 48'hfedc_ba98_7654;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [47:0] lw;
  logic lwv;
  logic [3:0] refv = 4'h0;
  logic mclr = 1'b0;
  logic mstrb;
  logic [47:0] tw;
  logic cl;
  logic [1:0] pr;
  logic lf;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic [47:0] base = 48'h0000_0000_0000;
  logic [31:0] rd;
  logic er;
  logic froze = 1'b0;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int gap;
  row_s rows [11] = '{
    '{1'b0, tw_pkg::IDX_AVG_INTERVAL, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{1'b0, tw_pkg::IDX_AVG_OPTIONS, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, tw_pkg::IDX_LOOP_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, tw_pkg::IDX_EVENT_MASK, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, tw_pkg::IDX_FREE_WORD_LO, 32'h1111_2222, 32'h1111_2222, 1'b0},
    '{1'b1, tw_pkg::IDX_FREE_WORD_HI, 32'h0000_3333, 32'h0000_3333, 1'b0},
    '{1'b1, tw_pkg::IDX_HIST_CLEAR, 32'h0000_0004, 32'h0000_0000, 1'b0},
    '{1'b1, 14'h0123, 32'hffff_ffff, 32'h0000_0000, 1'b1},
    '{1'b1, tw_pkg::IDX_EVENT_MASK, 32'h0000_0001, 32'h0000_0001, 1'b0},
    '{1'b1, tw_pkg::IDX_AVG_INTERVAL, 32'h0000_0020, 32'h0000_0020, 1'b0},
    '{1'b1, tw_pkg::IDX_AVG_OPTIONS, 32'h0000_0002, 32'h0000_0002, 1'b0}
  };

  // A small ms count keeps a 32 ms interval at 256 cycles.
  tuning_word_history_holdover #(.MS_CYCLES(8)) dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .loop_word_i(lw), .loop_word_valid_i(lwv), .ref_valid_i(refv), .mf_hist_clear_i(mclr),
    .mf_strobe_o(mstrb), .tuning_word_o(tw), .closed_loop_o(cl), .profile_load_o(),
    .profile_ref_o(pr), .lock_freeze_o(lf)
  );
  loop_filter_model lf_u (
    .clk_i(clk_sys_i), .rstn_i(rstn_i), .hold_i(hold), .slow_i(slow), .base_i(base), .word_o(lw), .valid_o(lwv)
  );

  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (lf === 1'b1) froze <= 1'b1;
    if (cyc == 10000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    cmp({47'h0000_0000_0000, pready}, 48'h0000_0000_0001, "bus ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic status(input int b, input logic exp, input string what);
    apb(1'b0, tw_pkg::IDX_STATUS, 32'h0000_0000);
    cmp({47'h0000_0000_0000, rd[b]}, {47'h0000_0000_0000, exp}, what);
  endtask
  task automatic avg(input logic [47:0] exp, input string what);
    logic [31:0] lo;
    apb(1'b0, tw_pkg::IDX_STORED_AVG_LO, 32'h0000_0000);
    lo = rd;
    apb(1'b0, tw_pkg::IDX_STORED_AVG_HI, 32'h0000_0000);
    cmp({rd[15:0], lo}, exp, what);
  endtask
  task automatic wait_cl(input logic v);
    int n;
    n = 0;
    while (cl !== v && n < 64) begin
      @(posedge clk_sys_i);
      n++;
    end
    cmp({47'h0000_0000_0000, cl}, {47'h0000_0000_0000, v}, "loop state");
  endtask
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (mstrb !== 1'b1 && n < 600);
    cmp({47'h0000_0000_0000, mstrb}, 48'h0000_0000_0001, "strobe");
  endtask
  task automatic loop_ctrl(input logic [31:0] v);
    apb(1'b1, tw_pkg::IDX_LOOP_CTRL, v);
    repeat (4) @(posedge clk_sys_i);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    base <= WORD_A;
    @(posedge clk_sys_i);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 32'h0000_0000);
      cmp({16'h0000, rd}, {16'h0000, rows[i].exp}, "register read");
      cmp({47'h0000_0000_0000, er}, {47'h0000_0000_0000, rows[i].err}, "slave error");
    end
    loop_ctrl(32'h0000_0020);
    cmp(tw, FREE_W, "free-run word");
    $display("test registers done");
    loop_ctrl(32'h0000_0000);
    cmp(tw, FREE_W, "holdover free word");
    refv <= 4'h1;
    wait_cl(1'b1);
    cmp({46'h0000_0000_0000, pr}, 48'h0000_0000_0000, "profile reference");
    apb(1'b1, tw_pkg::IDX_HIST_CLEAR, 32'h0000_0004);
    repeat (200) @(posedge clk_sys_i);
    cmp(tw, WORD_A, "closed-loop word");
    status(0, 1'b1, "early history");
    status(1, 1'b0, "no strobe yet");
    avg(WORD_A, "intermediate average");
    wait_strobe(gap);
    wait_strobe(gap);
    cmp(48'(gap), 48'h0000_0000_0100, "interval length");
    status(1, 1'b1, "updated flag");
    apb(1'b1, tw_pkg::IDX_STATUS, 32'h0000_0002);
    status(1, 1'b0, "updated flag cleared");
    repeat (220) @(posedge clk_sys_i);
    hold <= 1'b1;
    wait_strobe(gap);
    base <= WORD_B;
    slow <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    hold <= 1'b0;
    wait_strobe(gap);
    repeat (100) @(posedge clk_sys_i);
    avg(WORD_B, "memoryless average");
    $display("test averaging done");
    slow <= 1'b0;
    base <= WORD_A;
    refv <= 4'h0;
    wait_cl(1'b0);
    repeat (4) @(posedge clk_sys_i);
    cmp(tw, WORD_B, "holdover word");
    apb(1'b0, tw_pkg::IDX_STATUS, 32'h0000_0000);
    cmp({44'h000_0000_0000, rd[7:4]}, 48'h0000_0000_0004, "holdover state");
    apb(1'b1, tw_pkg::IDX_LOOP_CTRL, 32'h0000_0040);
    refv <= 4'h1;
    repeat (20) @(posedge clk_sys_i);
    cmp({47'h0000_0000_0000, cl}, 48'h0000_0000_0000, "user holdover");
    apb(1'b1, tw_pkg::IDX_LOOP_CTRL, 32'h0000_0000);
    wait_cl(1'b1);
    $display("test holdover done");
    apb(1'b1, tw_pkg::IDX_HIST_CLEAR, 32'h0000_0004);
    status(0, 1'b0, "history cleared");
    loop_ctrl(32'h0000_0040);
    cmp(tw, FREE_W, "fallback free word");
    apb(1'b1, tw_pkg::IDX_AVG_OPTIONS, 32'h0000_0012);
    apb(1'b1, tw_pkg::IDX_LOOP_CTRL, 32'h0000_0000);
    wait_cl(1'b1);
    apb(1'b1, tw_pkg::IDX_HIST_CLEAR, 32'h0000_0004);
    loop_ctrl(32'h0000_0040);
    cmp(tw, WORD_A, "fallback last word");
    apb(1'b1, tw_pkg::IDX_LOOP_CTRL, 32'h0000_0000);
    wait_cl(1'b1);
    repeat (200) @(posedge clk_sys_i);
    status(0, 1'b1, "intermediate history");
    mclr <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    mclr <= 1'b0;
    status(0, 1'b0, "pin clear");
    loop_ctrl(32'h0000_0020);
    cmp(tw, FREE_W, "forced free-run");
    $display("test clear and fallback done");
    apb(1'b1, tw_pkg::IDX_LOOP_CTRL, 32'h0000_0000);
    wait_cl(1'b1);
    repeat (200) @(posedge clk_sys_i);
    apb(1'b1, tw_pkg::IDX_AVG_OPTIONS, 32'h0000_001a);
    refv <= 4'h5;
    froze <= 1'b0;
    loop_ctrl(32'h0000_0012);
    cmp({46'h0000_0000_0000, pr}, 48'h0000_0000_0002, "forced reference");
    cmp({47'h0000_0000_0000, froze}, 48'h0000_0000_0001, "lock freeze");
    status(0, 1'b1, "persistent history");
    apb(1'b1, tw_pkg::IDX_AVG_OPTIONS, 32'h0000_0012);
    loop_ctrl(32'h0000_0010);
    status(0, 1'b0, "history discarded");
    $display("test switchover done");
    wrap_up();
  end
endmodule
